/* src/acc_ctrl.sv */
// Purpose: Calibration, coefficient load and result control for a 16-bit converter
// Assumes: clock_i is the conversion clock; raw_code_i is the signed array code
// Notes: Word 0 of the coefficients is the offset, the rest belong to linearity
// Behaviour
// - Execute bit sets start flag, starts calibration
// - Linearity phase, then gain phase, then idle
// - Calibration end interrupt when select is 11b
// - Flag high during calibration, cleared at end
// - Calibration lasts 24 ms at 32 MHz
// - Coefficients load from nonvolatile memory at startup
// - Diagnosis select 10 offset, 01/11 gain
// - Unsigned single-ended channels give 0 to 32767
// - Odd paired channels negative, or inverted
// - Differential and diagnosis results are signed
// - Averaging two to sixteen conversions
// - Approximation 18 cycles, gain 10 cycles
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_ctrl
    import acc_pkg::*;
#(
    parameter int CAL_CYCLES = `ACC_CAL_CYCLES,
    parameter int COEF_WORDS = `ACC_COEF_WORDS
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic calibration_execute_i,
    input wire logic trigger_i,
    input wire logic [1:0] interrupt_source_select_i,
    input wire logic [1:0] self_diag_level_select_i,
    input wire logic odd_channel_invert_i,
    input wire logic diff_mode_i,
    input wire logic self_diag_i,
    input wire logic [4:0] channel_i,
    input wire logic [2:0] avg_select_i,
    input wire logic [15:0] raw_code_i,
    output logic nvm_rd_o,
    output logic [1:0] nvm_addr_o,
    input wire logic nvm_valid_i,
    input wire logic [15:0] nvm_data_i,
    output logic conversion_start_flag_o,
    output logic scan_end_irq_o,
    output logic cal_lin_o,
    output logic cal_gain_o,
    output logic diag_offset_sel_o,
    output logic diag_gain_sel_o,
    output logic [15:0] result_o,
    output logic result_valid_o,
    output logic [15:0] offset_coef_o
);
    localparam int GAIN_CAL = CAL_CYCLES / 4;
    localparam int LIN_CAL = CAL_CYCLES - GAIN_CAL;

    typedef struct packed {
        acc_state_t st;
        logic [23:0] cnt;
        logic [23:0] cal_len;
        logic [1:0] nvm_addr;
        logic [COEF_WORDS-1:0][15:0] coef;
        logic [COEF_WORDS-1:0][15:0] shadow;
        logic flag;
        logic irq;
        logic diag_off;
        logic diag_gain;
        logic g_busy;
        logic [3:0] g_cnt;
        logic [15:0] g_data;
        logic [4:0] conv_cnt;
        logic diff;
        logic diag;
        logic inv;
        logic [4:0] ch;
        logic [2:0] avg_log2;
        logic [15:0] result;
        logic res_valid;
    } acc_st_t;

    acc_st_t s_reg;
    acc_st_t s_next;
    acc_avg_if avg_if ();
    logic [2:0] log2_sel;
    logic gain_done;
    logic cal_end;
    logic start_conv;

    acc_avg u_avg (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .av(avg_if.avgr)
    );

    // Offset removal with saturation to the signed word
    function automatic acc_word_t sat_sub(input acc_word_t a, input acc_word_t b);
        logic signed [16:0] d;
        d = 17'(a) - 17'(b);
        if (d > 17'sh07FFF) begin
            sat_sub = 16'sh7FFF;
        end else if (d < -17'sh08000) begin
            sat_sub = -16'sh8000;
        end else begin
            sat_sub = d[15:0];
        end
    endfunction

    function automatic logic [15:0] fmt(input acc_word_t v, input logic diff, input logic diag,
                                        input logic [4:0] ch, input logic inv);
        logic signed [16:0] neg;
        neg = -17'(v);
        fmt = v;
        if (diff || diag) begin
            fmt = v;
        end else if (ch <= `ACC_CH_PAIRED_LAST && ch[0]) begin
            if (!inv) begin
                fmt = (v > 16'sh0000) ? 16'h0000 : v;
            end else if (neg < 17'sh00000) begin
                fmt = 16'h0000;
            end else if (neg > 17'sh07FFF) begin
                fmt = `ACC_POS_MAX;
            end else begin
                fmt = neg[15:0];
            end
        end else begin
            fmt = (v < 16'sh0000) ? 16'h0000 : v;
        end
    endfunction

    assign log2_sel = (avg_select_i > `ACC_AVG_MAX_LOG2) ? `ACC_AVG_MAX_LOG2 : avg_select_i;
    assign gain_done = s_reg.g_busy && s_reg.g_cnt == 4'(`ACC_GAIN_CYCLES - 1);
    assign cal_end = s_reg.st == ST_CAL_GAIN && s_reg.cnt == 24'(GAIN_CAL - 1);
    assign start_conv = s_reg.st == ST_IDLE && !calibration_execute_i && trigger_i;

    assign avg_if.clr = start_conv;
    assign avg_if.in_valid = gain_done;
    assign avg_if.sample = sat_sub(s_reg.g_data, s_reg.coef[0]);
    assign avg_if.log2 = s_reg.avg_log2;

    always_comb begin
        s_next = s_reg;
        s_next.irq = 1'b0;
        s_next.res_valid = 1'b0;
        s_next.diag_off = self_diag_level_select_i == `ACC_DIAG_OFFSET;
        s_next.diag_gain = self_diag_level_select_i[0];
        if (gain_done) begin
            s_next.g_busy = 1'b0;
        end else if (s_reg.g_busy) begin
            s_next.g_cnt = s_reg.g_cnt + 4'h1;
        end
        if (avg_if.out_valid) begin
            s_next.result = fmt(avg_if.avg, s_reg.diff, s_reg.diag, s_reg.ch, s_reg.inv);
            s_next.res_valid = 1'b1;
        end
        case (s_reg.st)
            ST_LOAD: begin
                if (nvm_valid_i) begin
                    s_next.coef[s_reg.nvm_addr] = nvm_data_i;
                    s_next.shadow[s_reg.nvm_addr] = nvm_data_i;
                    s_next.nvm_addr = s_reg.nvm_addr + 2'h1;
                    if (s_reg.nvm_addr == 2'(COEF_WORDS - 1)) begin
                        s_next.st = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (calibration_execute_i) begin
                    s_next.flag = 1'b1;
                    s_next.st = ST_CAL_LIN;
                    s_next.cnt = '0;
                    s_next.cal_len = 24'h000001;
                end else if (trigger_i) begin
                    s_next.flag = 1'b1;
                    s_next.st = ST_SAMPLE;
                    s_next.cnt = '0;
                    s_next.conv_cnt = '0;
                    s_next.diff = diff_mode_i;
                    s_next.diag = self_diag_i;
                    s_next.inv = odd_channel_invert_i;
                    s_next.ch = channel_i;
                    s_next.avg_log2 = log2_sel;
                end
            end
            ST_CAL_LIN: begin
                s_next.cnt = s_reg.cnt + 24'h1;
                s_next.cal_len = s_reg.cal_len + 24'h1;
                if (s_reg.cnt == 24'(LIN_CAL - 1)) begin
                    for (int i = 1; i < COEF_WORDS; i++) begin
                        s_next.shadow[i] = raw_code_i;
                    end
                    s_next.st = ST_CAL_GAIN;
                    s_next.cnt = '0;
                end
            end
            ST_CAL_GAIN: begin
                s_next.cnt = s_reg.cnt + 24'h1;
                s_next.cal_len = s_reg.cal_len + 24'h1;
                if (cal_end) begin
                    s_next.coef = s_reg.shadow;
                    s_next.coef[0] = raw_code_i;
                    s_next.shadow[0] = raw_code_i;
                    s_next.flag = 1'b0;
                    s_next.irq = interrupt_source_select_i == `ACC_IRQ_SEL_CAL;
                    s_next.st = ST_IDLE;
                end
            end
            ST_SAMPLE: begin
                s_next.cnt = s_reg.cnt + 24'h1;
                if (s_reg.cnt == 24'(`ACC_SPL_CYCLES - 1)) begin
                    s_next.st = ST_SAR;
                    s_next.cnt = '0;
                end
            end
            ST_SAR: begin
                s_next.cnt = s_reg.cnt + 24'h1;
                if (s_reg.cnt == 24'(`ACC_SAR_CYCLES - 1)) begin
                    s_next.g_busy = 1'b1;
                    s_next.g_cnt = '0;
                    s_next.g_data = raw_code_i;
                    s_next.conv_cnt = s_reg.conv_cnt + 5'h01;
                    s_next.cnt = '0;
                    if (s_reg.conv_cnt + 5'h01 == 5'(5'h01 << s_reg.avg_log2)) begin
                        s_next.st = ST_GAIN;
                    end else begin
                        s_next.st = ST_SAMPLE;
                    end
                end
            end
            ST_GAIN: begin
                if (avg_if.out_valid) begin
                    s_next.flag = 1'b0;
                    s_next.irq = interrupt_source_select_i == `ACC_IRQ_SEL_SCAN;
                    s_next.st = ST_IDLE;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.st <= ST_LOAD;
        end else begin
            s_reg <= s_next;
        end
    end

    assign nvm_rd_o = s_reg.st == ST_LOAD;
    assign nvm_addr_o = s_reg.nvm_addr;
    assign conversion_start_flag_o = s_reg.flag;
    assign scan_end_irq_o = s_reg.irq;
    assign cal_lin_o = s_reg.st == ST_CAL_LIN;
    assign cal_gain_o = s_reg.st == ST_CAL_GAIN;
    assign diag_offset_sel_o = s_reg.diag_off;
    assign diag_gain_sel_o = s_reg.diag_gain;
    assign result_o = s_reg.result;
    assign result_valid_o = s_reg.res_valid;
    assign offset_coef_o = s_reg.coef[0];

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    AST_CAL_START: assert property (
        s_reg.st == ST_IDLE && calibration_execute_i |=> conversion_start_flag_o && cal_lin_o)
        else $error("Calibration did not start");
    AST_CAL_ORDER: assert property (
        ($rose(cal_gain_o) || $fell(cal_lin_o)) |-> cal_gain_o && $past(cal_lin_o) && s_reg.cnt == 24'h000000)
        else $error("Gain phase did not follow linearity phase");
    AST_CAL_IRQ: assert property (
        cal_end && interrupt_source_select_i == 2'h3 |=> scan_end_irq_o ##1 !scan_end_irq_o)
        else $error("Calibration end interrupt missing");
    AST_CAL_FLAG: assert property (
        (cal_lin_o || cal_gain_o) |-> conversion_start_flag_o ##1 conversion_start_flag_o == (cal_lin_o || cal_gain_o))
        else $error("Start flag wrong around calibration");
    AST_CAL_LEN: assert property (
        cal_end |-> s_reg.cal_len == 24'(CAL_CYCLES))
        else $error("Calibration length differs from set time");
    AST_NVM_LOAD: assert property (
        s_reg.st == ST_LOAD && nvm_valid_i && nvm_addr_o == 2'(COEF_WORDS - 1) |=> s_reg.st == ST_IDLE
        && !nvm_rd_o && s_reg.coef[COEF_WORDS-1] == $past(nvm_data_i))
        else $error("Coefficient load did not finish");
    AST_DIAG_SEL: assert property (
        self_diag_level_select_i == 2'h2 |=> diag_offset_sel_o && !diag_gain_sel_o)
        else $error("Offset level not selected");
    AST_UNSIGNED: assert property (
        result_valid_o && !s_reg.diff && !s_reg.diag && (s_reg.ch > 5'h07 || !s_reg.ch[0]) |-> !result_o[15])
        else $error("Unsigned channel gave negative result");
    AST_ODD_RANGE: assert property (
        result_valid_o && !s_reg.diff && !s_reg.diag && s_reg.ch <= 5'h07 && s_reg.ch[0]
        |-> (s_reg.inv ? !result_o[15] : (result_o[15] || result_o == 16'h0000)))
        else $error("Odd channel result out of range");
    AST_SAR_LEN: assert property (
        $rose(s_reg.st == ST_SAR) |-> (s_reg.st == ST_SAR) [*8] ##10 s_reg.st == ST_SAR
        ##1 s_reg.st != ST_SAR && s_reg.g_busy && s_reg.g_cnt == 4'h0)
        else $error("Approximation length wrong");
    AST_GAIN_LEN: assert property (
        $rose(s_reg.g_busy) |-> ##9 avg_if.in_valid)
        else $error("Gain correction length wrong");
    AST_CAL_IGNORE: assert property (
        (cal_lin_o || cal_gain_o) && !cal_end |=> !(s_reg.st inside {ST_SAMPLE, ST_SAR})
        ##0 $stable(offset_coef_o))
        else $error("Trigger or coefficient change during calibration");

    COV_CAL: cover property (cal_end);
    COV_AVG16: cover property (result_valid_o && s_reg.avg_log2 == 3'h4);
    COV_INV: cover property (result_valid_o && s_reg.inv && s_reg.ch[0]);
endmodule

/* src/acc_params.svh */
// Purpose: Constants for the converter calibration control block
// Assumes: clock_i is the conversion clock
// Notes: Calibration and sampling times are kept in their own unit and their cycle counts derive from them; approximation and gain are given in cycles
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_COEF_WORDS 4
`define ACC_CAL_TIME_US 24000
`define ACC_CAL_REF_MHZ 32
`define ACC_CAL_CYCLES (`ACC_CAL_TIME_US * `ACC_CAL_REF_MHZ)
`define ACC_T_SPL_NS 250
`define ACC_CLK_PERIOD_NS 8
`define ACC_SPL_CYCLES ((`ACC_T_SPL_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_SAR_CYCLES 18
`define ACC_GAIN_CYCLES 10
`define ACC_IRQ_SEL_CAL 2'h3
`define ACC_IRQ_SEL_SCAN 2'h1
`define ACC_DIAG_OFFSET 2'h2
`define ACC_AVG_MAX_LOG2 3'h4
`define ACC_CH_PAIRED_LAST 5'h07
`define ACC_POS_MAX 16'h7FFF
`define ACC_COEF_RST 16'h0000
`endif

/* src/acc_pkg.sv */
// Purpose: Types shared by the calibration control modules
// Assumes: Nothing beyond the constants header
// Notes: States are one-hot
package acc_pkg;
    typedef enum logic [6:0] {
        ST_LOAD = 7'h01,
        ST_IDLE = 7'h02,
        ST_CAL_LIN = 7'h04,
        ST_CAL_GAIN = 7'h08,
        ST_SAMPLE = 7'h10,
        ST_SAR = 7'h20,
        ST_GAIN = 7'h40
    } acc_state_t;
    typedef logic signed [15:0] acc_word_t;
endpackage

/* src/acc_avg_if.sv */
// Purpose: Carries corrected samples to the averager and the mean back
// Assumes: One clock domain
// Notes: clr restarts accumulation
`timescale 1ns/1ps
interface acc_avg_if;
    import acc_pkg::*;
    logic clr;
    logic in_valid;
    acc_word_t sample;
    logic [2:0] log2;
    logic out_valid;
    acc_word_t avg;
    modport ctrl (output clr, output in_valid, output sample, output log2, input out_valid, input avg);
    modport avgr (input clr, input in_valid, input sample, input log2, output out_valid, output avg);
endinterface

/* src/acc_avg.sv */
// Purpose: Averages 2**log2 consecutive samples
// Assumes: log2 stays stable while a burst is collected
// Notes: Arithmetic shift floors negative means
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_avg
    import acc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    acc_avg_if.avgr av
);
    typedef struct packed {
        logic signed [20:0] sum;
        logic [4:0] cnt;
        logic out_valid;
        acc_word_t avg;
    } acc_avg_st_t;

    acc_avg_st_t s_reg;
    acc_avg_st_t s_next;
    logic [4:0] target;
    logic signed [20:0] total;

    assign target = 5'(5'h01 << av.log2);
    assign total = s_reg.sum + 21'(av.sample);

    always_comb begin
        s_next = s_reg;
        s_next.out_valid = 1'b0;
        if (av.clr) begin
            s_next.sum = '0;
            s_next.cnt = '0;
        end else if (av.in_valid) begin
            if (s_reg.cnt + 5'h01 == target) begin
                s_next.avg = 16'(total >>> av.log2);
                s_next.out_valid = 1'b1;
                s_next.sum = '0;
                s_next.cnt = '0;
            end else begin
                s_next.sum = total;
                s_next.cnt = s_reg.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign av.out_valid = s_reg.out_valid;
    assign av.avg = s_reg.avg;

    AST_AVG_DONE: assert property (@(posedge clock_i) disable iff (rst_i)
        !av.clr && av.in_valid && s_reg.cnt + 5'h01 == target |=> av.out_valid)
        else $error("Average not delivered after last sample");
endmodule

/* verif/acc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the calibration control block
// Assumes: Calibration shortened to CAL cycles, offset coefficient ends at zero
// Notes: Inputs change 1 ns after the rising edge, outputs sampled there too
`timescale 1ns/1ps
module acc_ctrl_tb_top;
    import acc_pkg::*;
    localparam int CAL = 40;
    logic clock_i;
    logic rst_i;
    logic calibration_execute_i;
    logic trigger_i;
    logic [1:0] interrupt_source_select_i;
    logic [1:0] self_diag_level_select_i;
    logic odd_channel_invert_i;
    logic diff_mode_i;
    logic self_diag_i;
    logic [4:0] channel_i;
    logic [2:0] avg_select_i;
    logic [15:0] raw_code_i;
    logic nvm_rd_o;
    logic [1:0] nvm_addr_o;
    logic nvm_valid_i;
    logic [15:0] nvm_data_i;
    logic conversion_start_flag_o;
    logic scan_end_irq_o;
    logic cal_lin_o;
    logic cal_gain_o;
    logic diag_offset_sel_o;
    logic diag_gain_sel_o;
    logic [15:0] result_o;
    logic result_valid_o;
    logic [15:0] offset_coef_o;
    logic [15:0] res;
    int error_cnt = 0;
    int samples_checked = 0;

    acc_ctrl #(.CAL_CYCLES(CAL), .COEF_WORDS(4)) i_acc_ctrl (.clock_i(clock_i), .rst_i(rst_i),
        .calibration_execute_i(calibration_execute_i), .trigger_i(trigger_i),
        .interrupt_source_select_i(interrupt_source_select_i), .self_diag_level_select_i(self_diag_level_select_i),
        .odd_channel_invert_i(odd_channel_invert_i), .diff_mode_i(diff_mode_i), .self_diag_i(self_diag_i),
        .channel_i(channel_i), .avg_select_i(avg_select_i), .raw_code_i(raw_code_i), .nvm_rd_o(nvm_rd_o),
        .nvm_addr_o(nvm_addr_o), .nvm_valid_i(nvm_valid_i), .nvm_data_i(nvm_data_i),
        .conversion_start_flag_o(conversion_start_flag_o), .scan_end_irq_o(scan_end_irq_o),
        .cal_lin_o(cal_lin_o), .cal_gain_o(cal_gain_o), .diag_offset_sel_o(diag_offset_sel_o),
        .diag_gain_sel_o(diag_gain_sel_o), .result_o(result_o), .result_valid_o(result_valid_o),
        .offset_coef_o(offset_coef_o));

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Trigger stays high through a calibration so refusal is exercised
    task automatic run(input logic cal, input int exp_busy, input int exp_irq);
        int busy, irq, rv, lin, gain, bad;
        logic [15:0] coef;
        busy = 0;
        irq = 0;
        rv = 0;
        lin = 0;
        gain = 0;
        bad = 0;
        coef = offset_coef_o;
        calibration_execute_i = cal;
        trigger_i = 1'b1;
        @(posedge clock_i);
        #1;
        calibration_execute_i = 1'b0;
        trigger_i = cal;
        while (conversion_start_flag_o === 1'b1 && busy < 2000) begin
            busy++;
            lin += (cal_lin_o === 1'b1);
            gain += (cal_gain_o === 1'b1);
            if ((cal_lin_o === 1'b1 && gain > 0) || offset_coef_o !== coef) begin
                bad++;
            end
            @(posedge clock_i);
            #1;
            irq += (scan_end_irq_o === 1'b1);
            rv += (result_valid_o === 1'b1);
            if (result_valid_o === 1'b1) begin
                res = result_o;
            end
        end
        trigger_i = 1'b0;
        check("busy cycles", 16'(busy), 16'(exp_busy));
        check("irq pulses", 16'(irq), 16'(exp_irq));
        check("result pulses", 16'(rv), cal ? 16'h0000 : 16'h0001);
        check("linearity cycles", 16'(lin), cal ? 16'(CAL - CAL / 4) : 16'h0000);
        check("gain cycles", 16'(gain), cal ? 16'(CAL / 4) : 16'h0000);
        check("phase order or coef", 16'(bad), 16'h0000);
        // Idle edge so the next call never redrives trigger in this step
        @(posedge clock_i);
        #1;
    endtask

    task automatic conv(input logic d, input logic g, input logic inv, input logic [4:0] ch,
                        input logic [2:0] n, input logic [15:0] raw, input logic [15:0] exp);
        int k;
        k = (n > 3'h4) ? 4 : int'(n);
        diff_mode_i = d;
        self_diag_i = g;
        odd_channel_invert_i = inv;
        channel_i = ch;
        avg_select_i = n;
        raw_code_i = raw;
        // One conversion 61 busy cycles, each extra one 50 more
        run(1'b0, 61 + 50 * ((1 << k) - 1), 1);
        check("result", res, exp);
    endtask

    initial begin
        #(8 * 20000);
        error_cnt++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        calibration_execute_i = 1'b0;
        trigger_i = 1'b0;
        interrupt_source_select_i = 2'h0;
        self_diag_level_select_i = 2'h0;
        odd_channel_invert_i = 1'b0;
        diff_mode_i = 1'b0;
        self_diag_i = 1'b0;
        channel_i = 5'h00;
        avg_select_i = 3'h0;
        raw_code_i = 16'h0000;
        nvm_valid_i = 1'b0;
        nvm_data_i = 16'h0000;
        res = 16'h0000;
        repeat (20) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        @(posedge clock_i);
        #1;
        check("nvm_rd", nvm_rd_o, 16'h0001);
        check("start flag", conversion_start_flag_o, 16'h0000);
        trigger_i = 1'b1;
        for (int w = 0; w < 4; w++) begin
            nvm_valid_i = 1'b1;
            nvm_data_i = 16'h0A50 + 16'(w);
            check("nvm_addr", nvm_addr_o, 16'(w));
            @(posedge clock_i);
            #1;
        end
        nvm_valid_i = 1'b0;
        trigger_i = 1'b0;
        check("start flag", conversion_start_flag_o, 16'h0000);
        @(posedge clock_i);
        #1;
        check("nvm_rd", nvm_rd_o, 16'h0000);
        check("offset coef", offset_coef_o, 16'h0A50);
        nvm_valid_i = 1'b1;
        nvm_data_i = 16'h1111;
        @(posedge clock_i);
        #1;
        nvm_valid_i = 1'b0;
        check("offset coef", offset_coef_o, 16'h0A50);
        $display("test load done");
        for (int s = 0; s < 4; s++) begin
            self_diag_level_select_i = 2'(s);
            repeat (2) @(posedge clock_i);
            #1;
            check("diag offset sel", diag_offset_sel_o, 16'(s == 2));
            check("diag gain sel", diag_gain_sel_o, 16'(s % 2));
        end
        $display("test diag select done");
        // Last run leaves a zero offset so offset removal passes raw codes through unchanged
        for (int k = 0; k < 4; k++) begin
            interrupt_source_select_i = 2'(3 - k);
            raw_code_i = 16'(16'h0111 * (3 - k));
            run(1'b1, CAL, k == 0);
            check("new offset", offset_coef_o, 16'(16'h0111 * (3 - k)));
        end
        $display("test calibration done");
        interrupt_source_select_i = 2'h1;
        conv(1'b0, 1'b0, 1'b0, 5'h08, 3'h0, 16'h1234, 16'h1234);
        conv(1'b0, 1'b0, 1'b1, 5'h1F, 3'h0, 16'hFF00, 16'h0000);
        conv(1'b0, 1'b0, 1'b0, 5'h01, 3'h0, 16'h0100, 16'h0000);
        conv(1'b0, 1'b0, 1'b0, 5'h07, 3'h0, 16'hF000, 16'hF000);
        conv(1'b0, 1'b0, 1'b1, 5'h01, 3'h0, 16'hF000, 16'h1000);
        conv(1'b0, 1'b0, 1'b1, 5'h03, 3'h0, 16'h8000, 16'h7FFF);
        conv(1'b0, 1'b0, 1'b1, 5'h00, 3'h0, 16'h0200, 16'h0200);
        conv(1'b1, 1'b0, 1'b1, 5'h01, 3'h0, 16'hF000, 16'hF000);
        conv(1'b1, 1'b0, 1'b0, 5'h06, 3'h0, 16'h7FFF, 16'h7FFF);
        conv(1'b0, 1'b1, 1'b0, 5'h08, 3'h0, 16'h8000, 16'h8000);
        $display("test result ranges done");
        for (int n = 1; n < 6; n++) begin
            conv(1'b1, 1'b0, 1'b0, 5'h02, 3'(n), 16'hFFFD, 16'hFFFD);
        end
        conv(1'b0, 1'b1, 1'b0, 5'h08, 3'h4, 16'h8001, 16'h8001);
        $display("test averaging done");
        end_of_test();
    end
endmodule
